//--- rtl/sms_select_seq.v
// Chip-select and slave-ready sequencer for an SPI master port
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.vh"

module sms_select_seq (
    // Clock and reset
    input  wire                      sys_clk,
    input  wire                      reset_n,
    // Configuration
    input  wire                      clkPhase,
    input  wire                      clkPolarity,
    input  wire                      readyEnable,
    input  wire                      select_hold_en,
    input  wire [`SMS_DLY_W-1:0]     select_setup_delay,
    input  wire [`SMS_DLY_W-1:0]     select_hold_delay,
    input  wire [`SMS_DIV_W-1:0]     halfPeriod,
    input  wire [4:0]                bitCount,
    // Word request
    input  wire                      wordValid,
    output reg                       wordTaken,
    output reg                       wordDone,
    output reg                       busy,
    // Pins
    input  wire                      slave_ready_n,
    output reg                       slave_select_n,
    output reg                       serial_clk_pin
);

    // ---------------------------------------------------------------
    // States
    // ---------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_SETUP = 3'd1;
    localparam [2:0] ST_WAIT  = 3'd2;
    localparam [2:0] ST_PHASE = 3'd3;
    localparam [2:0] ST_SHIFT = 3'd4;
    localparam [2:0] ST_TAIL  = 3'd5;
    localparam [2:0] ST_HOLD  = 3'd6;

    // ---------------------------------------------------------------
    // Timing constants
    // ---------------------------------------------------------------
    // Setup floor in system cycles; the delay field is added on top
    localparam [7:0] SETUP_MIN = `SMS_SETUP_MIN_CYC;

    // Counters and decoded timing
    reg  [2:0]  state_q;
    reg  [7:0]  cnt_q;
    reg  [5:0]  edges_q;
    reg         readySync;
    wire        readyLow;
    wire [7:0]  setupCyc;
    wire [7:0]  holdCyc;
    wire [7:0]  half;
    wire [5:0]  edgeTotal;

    // ---------------------------------------------------------------
    // Ready line crossing
    // ---------------------------------------------------------------
    // Ready answer path: pin, two flops, then the wait state
    wire readySyncW;
    sms_sync uReadySync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .asyncIn (slave_ready_n),
        .syncOut (readySyncW)
    );
    // Local copy of the synchronised ready level
    always @* readySync = readySyncW;

    // ---------------------------------------------------------------
    // Derived counts
    // ---------------------------------------------------------------
    // Ready counts only when the handshake option is on
    assign readyLow  = !readyEnable || !readySync;
    // Minimum setup plus programmed extension
    assign setupCyc  = SETUP_MIN + {3'b000, select_setup_delay};
    // Zero half period would load 255 and give 256-cycle halves, so clamp to one
    assign half      = (halfPeriod == 8'h00) ? 8'h01 : halfPeriod;
    assign holdCyc   = {3'b000, select_hold_delay};
    // Two edges per bit; 32 bits wrap to zero, and the down-count
    // through 63 still yields all 64 edges
    assign edgeTotal = {bitCount, 1'b0} + 6'd2;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // One counter serves setup, half periods, tail and hold in turn
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Select released, clock parked low
            state_q        <= ST_IDLE;
            cnt_q          <= 8'h00;
            edges_q        <= 6'd0;
            slave_select_n <= 1'b1;
            serial_clk_pin <= 1'b0;
            wordTaken      <= 1'b0;
            wordDone       <= 1'b0;
            busy           <= 1'b0;
        end else begin
            wordTaken <= 1'b0;
            wordDone  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Park the clock first: a new idle level must not land
                    // on the select edge, so the word waits one cycle for it
                    serial_clk_pin <= clkPolarity;
                    busy           <= 1'b0;
                    if (wordValid && (serial_clk_pin == clkPolarity)) begin
                        wordTaken <= 1'b1;
                        busy      <= 1'b1;
                        if (slave_select_n) begin
                            // Fresh select: run the full setup count
                            slave_select_n <= 1'b0;
                            cnt_q          <= setupCyc - 8'd1;
                            state_q        <= ST_SETUP;
                        end else begin
                            // Select already held from previous word
                            cnt_q   <= 8'h00;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_SETUP: begin
                    // Count select-to-clock setup time
                    if (cnt_q == 8'h00) begin
                        state_q <= ST_WAIT;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                ST_WAIT: begin
                    // Clock held off while slave is not ready
                    if (readyLow) begin
                        // Load the first half period and the edge budget
                        cnt_q   <= half - 8'd1;
                        edges_q <= edgeTotal;
                        state_q <= clkPhase ? ST_PHASE : ST_SHIFT;
                        // Phase 0 makes its first edge now
                        if (!clkPhase) begin
                            serial_clk_pin <= ~serial_clk_pin;
                            edges_q        <= edgeTotal - 6'd1;
                        end
                    end
                end
                ST_PHASE: begin
                    // Phase 1 adds a half period before the first edge
                    if (cnt_q == 8'h00) begin
                        serial_clk_pin <= ~serial_clk_pin;
                        edges_q        <= edges_q - 6'd1;
                        cnt_q          <= half - 8'd1;
                        state_q        <= ST_SHIFT;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                ST_SHIFT: begin
                    // Toggle every half period until the edge budget is spent
                    if (cnt_q == 8'h00) begin
                        if (edges_q == 6'd0) begin
                            // Last edge is half a period old here
                            if (clkPhase) begin
                                // Phase 1 may release at once
                                cnt_q   <= holdCyc;
                                state_q <= ST_HOLD;
                            end else begin
                                // Phase 0 waits a further half period
                                cnt_q   <= half - 8'd1;
                                state_q <= ST_TAIL;
                            end
                        end else begin
                            serial_clk_pin <= ~serial_clk_pin;
                            edges_q        <= edges_q - 6'd1;
                            cnt_q          <= half - 8'd1;
                        end
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                ST_TAIL: begin
                    // Phase 0 tail before the hold count
                    if (cnt_q == 8'h00) begin
                        cnt_q   <= holdCyc;
                        state_q <= ST_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                ST_HOLD: begin
                    // Programmed hold, then release or keep select
                    if (cnt_q == 8'h00) begin
                        wordDone <= 1'b1;
                        state_q  <= ST_IDLE;
                        // Keep select low only when more data is queued
                        if (!(select_hold_en && wordValid)) begin
                            slave_select_n <= 1'b1;
                        end
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                default: begin
                    // Unused codes fall back to idle
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // sms_select_seq

`default_nettype wire

//--- rtl/sms_sync.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module sms_sync (
    // Clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // Level in and out
    input  wire asyncIn,
    output reg  syncOut
);

    reg meta_q;

    // First flop feeds only the second
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q  <= 1'b1;
            syncOut <= 1'b1;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule // sms_sync

`default_nettype wire

//--- shared/sms_defs.vh
// Timing and field constants for the SPI master select sequencer
`ifndef SMS_DEFS_VH
`define SMS_DEFS_VH

// System clock period in ps (250 MHz)
`define SMS_SYS_PERIOD_PS     4000
// Least select-to-clock time is 2P - 10 ns; in cycles, rounded up
`define SMS_SETUP_MARGIN_NS   10
`define SMS_SETUP_MIN_CYC     8'h02
// Longest ready-to-clock time is 3P + 15 ns; in cycles, rounded down
`define SMS_READY_MARGIN_NS   15
`define SMS_READY_MAX_CYC     8'h03
// Delay field width
`define SMS_DLY_W             5
// Serial half-period divider width
`define SMS_DIV_W             8
// Default serial half period in system cycles
`define SMS_HALF_DEF          8'h08

`endif

//--- test/sms_select_seq_asserts.sv
// Port-level checks for the select sequencer
`timescale 1ns/1ps
`default_nettype none
module sms_select_seq_asserts (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // Configuration
    input wire logic       clkPhase,
    input wire logic       readyEnable,
    input wire logic       select_hold_en,
    input wire logic [4:0] select_setup_delay,
    input wire logic [4:0] select_hold_delay,
    input wire logic [7:0] halfPeriod,
    // Handshake and pins
    input wire logic       wordValid,
    input wire logic       wordDone,
    input wire logic       slave_ready_n,
    input wire logic       slave_select_n,
    input wire logic       serial_clk_pin
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Slave holds the port off; 8 cycles covers the ready synchroniser
    sequence stallS;
        (!slave_select_n && slave_ready_n && readyEnable)[*8];
    endsequence
    sequence resumeS;
        !slave_ready_n && !clkPhase && select_setup_delay < 5'h02;
    endsequence
    setup_min_a: assert property ($fell(slave_select_n) |-> ##1 $stable(serial_clk_pin)[*2])
        else $error("clock edge too soon after select");
    setup_half_a: assert property ($fell(slave_select_n) && clkPhase && halfPeriod == 8'h04
        |-> ##1 $stable(serial_clk_pin)[*5]) else $error("phase one setup too short");
    setup_long_a: assert property ($fell(slave_select_n) && select_setup_delay == 5'h1f
        |-> ##1 $stable(serial_clk_pin)[*8]) else $error("setup delay not applied");
    hold_min_a: assert property ($rose(slave_select_n) && !clkPhase |->
        $past(serial_clk_pin) == serial_clk_pin && $past(serial_clk_pin, 2) == serial_clk_pin)
        else $error("select released too soon after last edge");
    hold_long_a: assert property ($rose(slave_select_n) && select_hold_delay == 5'h1f
        |-> $past(serial_clk_pin, 8) == serial_clk_pin) else $error("hold delay not applied");
    keep_select_a: assert property (wordDone && $past(select_hold_en && wordValid)
        |-> !slave_select_n ##1 !slave_select_n) else $error("select dropped between words");
    stall_clock_a: assert property (stallS |-> $stable(serial_clk_pin))
        else $error("clock ran while slave not ready");
    ready_resume_a: assert property (stallS ##1 resumeS |-> ##[1:6] $changed(serial_clk_pin))
        else $error("clock late after ready");
endmodule // sms_select_seq_asserts
bind sms_select_seq sms_select_seq_asserts u_chk (.sys_clk, .reset_n, .clkPhase, .readyEnable,
    .select_hold_en, .select_setup_delay, .select_hold_delay, .halfPeriod, .wordValid,
    .wordDone, .slave_ready_n, .slave_select_n, .serial_clk_pin);
`default_nettype wire

//--- test/sms_slave_model.sv
// Behavioural SPI slave answering select on its ready line
`timescale 1ns/1ps
`default_nettype none
module sms_slave_model (
    // Own clock and stall length
    input wire logic       linkClk,
    input wire logic [1:0] stallTicks,
    // Pins
    input wire logic       slave_select_n,
    output var logic       slave_ready_n
);
    logic [1:0] cnt;
    // Not ready at once on select, ready after stallTicks plus one own ticks
    // Not ready again from select release, holding off the next word
    always @(posedge linkClk or posedge slave_select_n) begin
        if (slave_select_n) begin
            slave_ready_n <= 1'b1;
            cnt <= stallTicks;
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else begin
            slave_ready_n <= 1'b0;
        end
    end
endmodule // sms_slave_model
`default_nettype wire

//--- test/testbench.sv
// Random and corner-case bench for the select sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin samplesChecked++; if ((s) !== (e)) begin nErrors++; \
    $display("mismatch %s exp %0d got %0d", n, e, s); end end
module testbench;
    logic        sys_clk = 1'b0, reset_n = 1'b0, linkClk = 1'b0, wordValid = 1'b0;
    logic        clkPhase = 1'b0, clkPolarity = 1'b0, readyEnable = 1'b0, select_hold_en = 1'b0;
    logic        wordTaken, wordDone, busy, slave_ready_n, slave_select_n, serial_clk_pin;
    logic [4:0]  select_setup_delay = 5'h00, select_hold_delay = 5'h00, bitCount = 5'h00;
    logic [7:0]  halfPeriod = 8'h01;
    logic [1:0]  stallTicks = 2'h0;
    logic [31:0] rng = 32'hd916;
    int          nErrors = 0, samplesChecked = 0, cyc = 0, tFall, tFirst, tLast, tRise, edges;
    initial forever #2 sys_clk = ~sys_clk;
    // Slave clock, phase unrelated to sys_clk
    initial begin
        #7;
        forever #32 linkClk = ~linkClk;
    end
    sms_select_seq u_dut (.sys_clk, .reset_n, .clkPhase, .clkPolarity, .readyEnable,
        .select_hold_en, .select_setup_delay, .select_hold_delay, .halfPeriod, .bitCount,
        .wordValid, .wordTaken, .wordDone, .busy, .slave_ready_n, .slave_select_n,
        .serial_clk_pin);
    sms_slave_model u_slave (.linkClk, .stallTicks, .slave_select_n, .slave_ready_n);
    // Cycle stamps of select and serial clock edges, plus hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if ($fell(slave_select_n)) tFall = cyc;
        if ($rose(slave_select_n)) tRise = cyc;
        if ($changed(serial_clk_pin) && !slave_select_n) begin
            if (edges == 0) tFirst = cyc;
            edges++;
            tLast = cyc;
        end
        if (cyc > 60000) begin
            nErrors++;
            printVerdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Least gap in cycles: base plus delay field, plus half period when asked
    function automatic int expGap(input int base, input logic [4:0] d, input logic addHalf);
        return base + d + (addHalf ? halfPeriod : 0);
    endfunction
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One word; keep leaves the request up so the next word follows under held select
    task automatic runWord(input logic keep);
        int n;
        logic fresh;
        n = 0;
        fresh = slave_select_n;
        edges = 0;
        wordValid = 1'b1;
        while (wordTaken !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        wordValid = keep;
        while (wordDone !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        // A word that never finishes counts against the run
        if (n >= 3000) nErrors++;
        @(negedge sys_clk);
        `CHK("edges", 2 * (bitCount + 1), edges)
        `CHK("busy", keep, busy)
        if (fresh) `CHK("setup", 1'b1, tFirst - tFall >= expGap(2, select_setup_delay, clkPhase))
        if (keep) `CHK("held", 1'b0, slave_select_n)
        else `CHK("hold", 1'b1, tRise - tLast >= expGap(0, select_hold_delay, !clkPhase))
        if (!keep) repeat (4) @(negedge sys_clk);
        $display("word end phase %0d keep %0d", clkPhase, keep);
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        for (int i = 0; i < 40; i++) begin
            rng = xs(rng);
            {clkPhase, clkPolarity, readyEnable, stallTicks, select_setup_delay} = rng[9:0];
            {select_hold_delay, bitCount, select_hold_en} = rng[20:10];
            halfPeriod = {6'h00, rng[22:21]} + 8'h01;
            if (i == 0) {select_setup_delay, select_hold_delay} = 10'h3ff;
            if (i == 1) {clkPhase, readyEnable, stallTicks, select_setup_delay} = 9'h0e0;
            if (i == 2) {clkPhase, halfPeriod} = 9'h104;
            if (i % 4 == 3) select_hold_en = 1'b1;
            if (i % 4 == 3) runWord(1'b1);
            runWord(1'b0);
        end
        printVerdict();
    end
endmodule // testbench
`default_nettype wire
